// ==== rtl/adc_cal_ctrl.sv ====
/*
 * ADC conversion and calibration sequencer with the calibration control SFR.
 * Assumes a SAR core that starts on conv_start and answers with sar_done, a
 * channel field and conversion request from the other ADC control registers,
 * and a DMA engine that presents channel identifiers read from memory.
 */
`timescale 1ns/10ps
`default_nettype none
module adc_cal_ctrl
	import adc_cal_pkg::*;
#(
	parameter logic [7:0] ACQ_CYCLES = DEF_ACQ_CYC
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// SFR access
	input wire sfr_req_s sfr,
	output logic [7:0] sfr_rdata,
	// Software conversion control
	input wire logic [3:0] chan_select,
	input wire logic conv_req,
	// DMA channel list
	input wire logic dma_mode,
	input wire logic dma_id_valid,
	input wire logic [3:0] dma_chan_id,
	output logic dma_id_ready,
	output logic dma_done,
	// Interrupt flag handling
	input wire logic int_vector_ack,
	input wire logic flag_sw_clear,
	output logic conversion_done_flag,
	// SAR core
	input wire logic sar_done,
	output logic conv_start,
	output logic sample_track,
	output route_s route,
	output logic result_valid,
	// Calibration results
	output logic cal_update,
	output logic cal_is_gain
);

	// Readings to average for a calibration
	function automatic logic [5:0] avg_readings(input logic [1:0] code);
		case (code)
			AVG_CODE_15: avg_readings = AVG_N_15;
			AVG_CODE_1: avg_readings = AVG_N_1;
			AVG_CODE_31: avg_readings = AVG_N_31;
			default: avg_readings = AVG_N_63;
		endcase
	endfunction

	seq_state_e state_ff, nxt_state;
	op_kind_e op_ff, nxt_op;
	logic [6:0] ctrl_ff, nxt_ctrl;
	logic [7:0] acq_cnt_ff, nxt_acq_cnt;
	logic [5:0] reads_ff, nxt_reads;
	logic [3:0] chan_ff, nxt_chan;
	logic flag_ff, nxt_flag;
	logic conv_start_ff, nxt_conv_start;
	logic result_valid_ff, nxt_result_valid;
	logic cal_update_ff, nxt_cal_update;
	logic dma_done_ff, nxt_dma_done;
	logic [7:0] rdata_ff, nxt_rdata;
	route_s route_ff, nxt_route;
	route_s dec_route;
	logic dec_stop;
	logic busy;
	logic ctrl_wr;
	logic cal_go;
	logic dma_take;
	logic [3:0] sel_code;
	logic [7:0] acq_load;

	// Busy is purely the sequencer state, never a stored software bit
	assign busy = (state_ff != ST_IDLE);
	assign ctrl_wr = sfr.wr && (sfr.addr == CAL_CTRL_ADDR);
	assign cal_go = ctrl_wr && sfr.wdata[CAL_START_BIT] && !busy;
	assign dma_take = dma_mode && dma_id_valid && !busy && !cal_go && !conv_req;

	// Channel for the decoder: calibration picks its reference node
	always_comb begin
		sel_code = chan_ff;
		if (state_ff == ST_IDLE) begin
			if (cal_go) begin
				sel_code = sfr.wdata[CAL_TYPE_BIT] ? CH_VREF : CH_AGND;
			end else if (conv_req) begin
				sel_code = chan_select;
			end else begin
				sel_code = dma_chan_id;
			end
		end
	end

	adc_chan_decode u_decode (
		.code(sel_code),
		.route(dec_route),
		.is_stop(dec_stop)
	);

	// The temperature sensor needs a longer track phase than the other inputs
	assign acq_load = (dec_route.temp && TEMP_ACQ_CYC > ACQ_CYCLES) ? TEMP_ACQ_CYC : ACQ_CYCLES;

	// Sequencer, register file and flags
	always_comb begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_ctrl = ctrl_ff;
		nxt_acq_cnt = acq_cnt_ff;
		nxt_reads = reads_ff;
		nxt_chan = chan_ff;
		nxt_route = route_ff;
		nxt_flag = flag_ff;
		nxt_conv_start = 1'b0;
		nxt_result_valid = 1'b0;
		nxt_cal_update = 1'b0;
		nxt_dma_done = 1'b0;
		nxt_rdata = rdata_ff;

		// Bits 6:1 follow every write; the start bit is only taken while idle
		if (ctrl_wr) begin
			nxt_ctrl[6:1] = sfr.wdata[6:1];
			if (!busy) begin
				nxt_ctrl[CAL_START_BIT] = sfr.wdata[CAL_START_BIT];
			end
		end

		case (state_ff)
			ST_IDLE: begin
				if (cal_go) begin
					nxt_op = OP_CAL;
					nxt_chan = sel_code;
					nxt_route = dec_route;
					nxt_reads = avg_readings(sfr.wdata[AVG_MSB:AVG_LSB]);
					nxt_acq_cnt = acq_load;
					// Gain calibration with the disable bit set runs no readings
					if (sfr.wdata[CAL_TYPE_BIT] && sfr.wdata[GAIN_DIS_BIT]) begin
						nxt_state = ST_FIN;
					end else begin
						nxt_state = ST_ACQ;
					end
				end else if (conv_req) begin
					nxt_op = OP_SINGLE;
					nxt_chan = sel_code;
					nxt_route = dec_route;
					nxt_reads = AVG_N_1;
					nxt_acq_cnt = acq_load;
					nxt_state = ST_ACQ;
				end else if (dma_take) begin
					if (dec_stop) begin
						nxt_dma_done = 1'b1;
					end else begin
						nxt_op = OP_DMA;
						nxt_chan = sel_code;
						nxt_route = dec_route;
						nxt_reads = AVG_N_1;
						nxt_acq_cnt = acq_load;
						nxt_state = ST_ACQ;
					end
				end
			end
			ST_ACQ: begin
				if (acq_cnt_ff <= 8'h01) begin
					nxt_conv_start = 1'b1;
					nxt_state = ST_CONV;
				end else begin
					nxt_acq_cnt = acq_cnt_ff - 8'h01;
				end
			end
			ST_CONV: begin
				if (sar_done) begin
					// Further calibration readings go back through acquisition
					if (reads_ff > 6'h01) begin
						nxt_reads = reads_ff - 6'h01;
						nxt_acq_cnt = acq_load;
						nxt_state = ST_ACQ;
					end else begin
						nxt_state = ST_FIN;
					end
				end
			end
			ST_FIN: begin
				nxt_state = ST_IDLE;
				nxt_route = '0;
				if (op_ff == OP_CAL) begin
					nxt_ctrl[CAL_START_BIT] = 1'b0;
					nxt_cal_update = !(ctrl_ff[CAL_TYPE_BIT] && ctrl_ff[GAIN_DIS_BIT]);
				end else begin
					nxt_result_valid = 1'b1;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase

		// Hardware set wins over either clear
		if (int_vector_ack || flag_sw_clear) begin
			nxt_flag = 1'b0;
		end
		if ((state_ff == ST_FIN && op_ff == OP_SINGLE) || (dma_take && dec_stop)) begin
			nxt_flag = 1'b1;
		end

		// Read data is captured on the read strobe
		if (sfr.rd && sfr.addr == CAL_CTRL_ADDR) begin
			nxt_rdata = {busy, ctrl_ff};
		end
	end

	// State registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_IDLE;
			op_ff <= OP_SINGLE;
			ctrl_ff <= CAL_CTRL_RESET[6:0];
			acq_cnt_ff <= 8'h00;
			reads_ff <= 6'h00;
			chan_ff <= 4'h0;
			route_ff <= '0;
			flag_ff <= 1'b0;
			conv_start_ff <= 1'b0;
			result_valid_ff <= 1'b0;
			cal_update_ff <= 1'b0;
			dma_done_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			ctrl_ff <= nxt_ctrl;
			acq_cnt_ff <= nxt_acq_cnt;
			reads_ff <= nxt_reads;
			chan_ff <= nxt_chan;
			route_ff <= nxt_route;
			flag_ff <= nxt_flag;
			conv_start_ff <= nxt_conv_start;
			result_valid_ff <= nxt_result_valid;
			cal_update_ff <= nxt_cal_update;
			dma_done_ff <= nxt_dma_done;
			rdata_ff <= nxt_rdata;
		end
	end

	// Outputs
	assign sfr_rdata = rdata_ff;
	assign dma_id_ready = dma_mode && !busy && !cal_go && !conv_req; // Handshake, combinational
	assign dma_done = dma_done_ff;
	assign conversion_done_flag = flag_ff;
	assign conv_start = conv_start_ff;
	assign sample_track = (state_ff == ST_ACQ);
	assign route = route_ff;
	assign result_valid = result_valid_ff;
	assign cal_update = cal_update_ff;
	assign cal_is_gain = ctrl_ff[CAL_TYPE_BIT];

endmodule
`default_nettype wire

// ==== rtl/adc_cal_pkg.sv ====
/*
 * Constants, types and register layout shared by the ADC channel routing and
 * calibration control logic.
 * Assumes an SFR space with 8-bit addresses and data, clocked by core_clk.
 */
package adc_cal_pkg;

	// Register placement and reset
	localparam logic [7:0] CAL_CTRL_ADDR = 8'hf5;
	localparam logic [7:0] CAL_CTRL_RESET = 8'h00;

	// Field positions in the calibration control register
	localparam int BUSY_BIT = 7;
	localparam int GAIN_DIS_BIT = 6;
	localparam int AVG_MSB = 5;
	localparam int AVG_LSB = 4;
	localparam int CAL_TYPE_BIT = 1;
	localparam int CAL_START_BIT = 0;

	// Average count codes and readings
	localparam logic [1:0] AVG_CODE_15 = 2'h0;
	localparam logic [1:0] AVG_CODE_1 = 2'h1;
	localparam logic [1:0] AVG_CODE_31 = 2'h2;
	localparam logic [5:0] AVG_N_15 = 6'h0f;
	localparam logic [5:0] AVG_N_1 = 6'h01;
	localparam logic [5:0] AVG_N_31 = 6'h1f;
	localparam logic [5:0] AVG_N_63 = 6'h3f;

	// High channel codes
	localparam logic [3:0] CH_TEMP = 4'h8;
	localparam logic [3:0] CH_DAC0 = 4'h9;
	localparam logic [3:0] CH_DAC1 = 4'ha;
	localparam logic [3:0] CH_AGND = 4'hb;
	localparam logic [3:0] CH_VREF = 4'hc;
	localparam logic [3:0] CH_DMA_STOP = 4'hf;

	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int TEMP_ACQ_NS = 1000;
	localparam logic [7:0] TEMP_ACQ_CYC = 8'((TEMP_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] DEF_ACQ_CYC = 8'h02;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ACQ = 4'b0010,
		ST_CONV = 4'b0100,
		ST_FIN = 4'b1000
	} seq_state_e;

	// Kind of operation in progress
	typedef enum logic [1:0] {
		OP_SINGLE = 2'h0,
		OP_DMA = 2'h1,
		OP_CAL = 2'h2
	} op_kind_e;

	// SFR access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sfr_req_s;

	// Analog multiplexer selection, at most one bit set
	typedef struct packed {
		logic [7:0] ain;
		logic temp;
		logic dac0;
		logic dac1;
		logic agnd;
		logic vref;
	} route_s;

endpackage

// ==== rtl/adc_chan_decode.sv ====
/*
 * Channel code decoder: turns a four-bit channel code into an analog mux
 * selection and flags the DMA stop marker.
 * Assumes the caller registers the outputs before they reach the analog side.
 */
`timescale 1ns/10ps
`default_nettype none
module adc_chan_decode
	import adc_cal_pkg::*;
(
	// Channel code
	input wire logic [3:0] code,
	// Decoded selection
	output route_s route,
	output logic is_stop
);

	// Low codes pick an external pin, high codes internal nodes
	always_comb begin
		route = '0;
		is_stop = 1'b0;
		if (!code[3]) begin
			route.ain[code[2:0]] = 1'b1;
		end else begin
			case (code)
				CH_TEMP: route.temp = 1'b1;
				CH_DAC0: route.dac0 = 1'b1;
				CH_DAC1: route.dac1 = 1'b1;
				CH_AGND: route.agnd = 1'b1;
				CH_VREF: route.vref = 1'b1;
				CH_DMA_STOP: is_stop = 1'b1;
				default: route = '0; // Unused codes leave the mux open
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== verification/adc_cal_sva.sv ====
/* Checker for the adc_cal_ctrl ports.
   Assumes ACQ_CYCLES of 2 and a SAR answered by the bench. */
`timescale 1ns/10ps
`default_nettype none
module adc_cal_sva
	import adc_cal_pkg::*;
#(parameter logic [7:0] ACQ_CYCLES = DEF_ACQ_CYC)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Inputs
	input wire sfr_req_s sfr,
	input wire logic dma_id_valid,
	input wire logic [3:0] dma_chan_id,
	input wire logic int_vector_ack,
	input wire logic flag_sw_clear,
	input wire logic sar_done,
	// Outputs
	input wire logic [7:0] sfr_rdata,
	input wire logic dma_id_ready,
	input wire logic dma_done,
	input wire logic conversion_done_flag,
	input wire logic conv_start,
	input wire logic sample_track,
	input wire route_s route,
	input wire logic result_valid,
	input wire logic cal_update
);
	// One domain, so clock and reset are given once
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Acquisition length ties sample start to the SAR start
	AST_ACQ: assert property ($rose(sample_track) && !route.temp |-> ##2 conv_start)
		else $error("short acquisition length wrong");
	AST_TEMP: assert property ($rose(sample_track) && route.temp |-> ##125 conv_start)
		else $error("sensor acquisition length wrong");
	AST_ONEHOT: assert property ($onehot0(route))
		else $error("more than one input routed");
	AST_STOP: assert property (dma_id_valid && dma_id_ready && dma_chan_id == CH_DMA_STOP
		|=> dma_done && conversion_done_flag)
		else $error("stop marker did not end the list");
	AST_FLAG_SET: assert property ($rose(conversion_done_flag) |-> result_valid || dma_done)
		else $error("flag set without a finished conversion");
	AST_FLAG_CLR: assert property ((int_vector_ack || flag_sw_clear)
		|=> !conversion_done_flag || result_valid || dma_done)
		else $error("flag not cleared");
	AST_BUSY: assert property (sfr.rd && sfr.addr == CAL_CTRL_ADDR && sample_track
		|=> sfr_rdata[BUSY_BIT])
		else $error("busy low during acquisition");
	AST_CAL_END: assert property (cal_update |-> $past(sar_done, 2))
		else $error("calibration ended without a reading");
	AST_RES: assert property (result_valid |-> $past(sar_done, 2) && !sample_track)
		else $error("result without a reading");
	// Main scenarios
	COV_RES: cover property (result_valid);
	COV_CAL: cover property (cal_update);
	COV_STOP: cover property (dma_done);
endmodule
`default_nettype wire

// ==== verification/adc_channel_select_and_calibration_tb.sv ====
/* Bench for adc_cal_ctrl: register, conversions, DMA list, calibration.
   Assumes a SAR that answers one cycle after each start. */
`timescale 1ns/10ps
`default_nettype none
module adc_channel_select_and_calibration_tb import adc_cal_pkg::*;;
	logic core_clk = 0, nrst = 0, conv_req = 0, dma_mode = 0, dma_id_valid = 0;
	logic int_vector_ack = 0, flag_sw_clear = 0, sar_done = 0;
	logic [3:0] chan_select = 0, dma_chan_id = 0;
	sfr_req_s sfr = '0;
	logic [7:0] sfr_rdata, rd, w;
	logic dma_id_ready, dma_done, conversion_done_flag, conv_start, sample_track;
	logic result_valid, cal_update, cal_is_gain;
	route_s route;
	logic [31:0] rs = 32'h058a;
	logic [3:0] c;
	int fail_count = 0, tests_run = 0, cyc = 0, n;
	adc_cal_ctrl dut_u (.core_clk(core_clk), .nrst(nrst), .sfr(sfr), .sfr_rdata(sfr_rdata),
		.chan_select(chan_select), .conv_req(conv_req), .dma_mode(dma_mode),
		.dma_id_valid(dma_id_valid), .dma_chan_id(dma_chan_id), .dma_id_ready(dma_id_ready),
		.dma_done(dma_done), .int_vector_ack(int_vector_ack), .flag_sw_clear(flag_sw_clear),
		.conversion_done_flag(conversion_done_flag), .sar_done(sar_done),
		.conv_start(conv_start), .sample_track(sample_track), .route(route),
		.result_valid(result_valid), .cal_update(cal_update), .cal_is_gain(cal_is_gain));
	// Clock
	initial forever #4 core_clk = ~core_clk;
	// SAR stand-in answers each start on the next cycle
	always @(posedge core_clk) sar_done <= #1 conv_start;
	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 20000) begin
			fail_count++;
			report_and_stop;
		end
	end
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	// Expected mux selection for a channel code
	function automatic route_s xr(input logic [3:0] k);
		route_s r;
		r = '0;
		if (!k[3]) r.ain[k[2:0]] = 1'b1;
		r.temp = (k == CH_TEMP);
		r.dac0 = (k == CH_DAC0);
		r.dac1 = (k == CH_DAC1);
		r.agnd = (k == CH_AGND);
		r.vref = (k == CH_VREF);
		return r;
	endfunction
	task tick;
		@(posedge core_clk);
		#1;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] d);
		sfr.addr = CAL_CTRL_ADDR;
		sfr.wdata = d;
		sfr.wr = 1;
		tick;
		sfr.wr = 0;
	endtask
	task rdr(input logic [7:0] a);
		sfr.addr = a;
		sfr.rd = 1;
		tick;
		sfr.rd = 0;
		rd = sfr_rdata;
	endtask
	// Hand one list entry over, held until taken
	task dma_id(input logic [3:0] k);
		dma_chan_id = k;
		dma_id_valid = 1;
		repeat (20) if (!dma_id_ready) tick;
		tick;
		dma_id_valid = 0;
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		#1 nrst = 1;
		rdr(CAL_CTRL_ADDR);
		chk("reset", 8'h00, rd);
		// Busy position written high and start bit written low, only bits 6:1 stick
		repeat (4) begin
			w = (8'(rnd()) | 8'h80) & 8'hf7;
			wr(w & 8'hfe);
			rdr(CAL_CTRL_ADDR);
			chk("stored", w & 8'h7e, rd);
			// Gap so the read strobe is not lowered and raised in one step
			tick;
			rdr(8'hf4);
			chk("other addr", w & 8'h7e, rd);
		end
		$display("register test done");
		// High codes first, then random external inputs
		for (int i = 0; i < 14; i++) begin
			c = (i < 7) ? 4'(8 + i) : 4'(rnd() % 8);
			chan_select = c;
			conv_req = 1;
			tick;
			conv_req = 0;
			chk("track", 1, sample_track);
			n = 0;
			do begin tick; n++; end while (!conv_start && n < 300);
			chk("acq", (c == CH_TEMP) ? 125 : 2, n);
			chk("route", xr(c), route);
			repeat (20) if (!result_valid) tick;
			chk("result", 1, result_valid);
			chk("flag set", 1, conversion_done_flag);
			if (i % 2) int_vector_ack = 1;
			else flag_sw_clear = 1;
			tick;
			int_vector_ack = 0;
			flag_sw_clear = 0;
			tick;
			chk("flag clr", 0, conversion_done_flag);
		end
		$display("conversion test done");
		dma_mode = 1;
		dma_id(4'h3);
		chk("dma route", xr(4'h3), route);
		chk("dma held off", 0, dma_id_ready);
		repeat (20) if (!result_valid) tick;
		chk("dma result", 1, result_valid);
		chk("dma flag", 0, conversion_done_flag);
		dma_id(CH_DMA_STOP);
		chk("dma done", 1, dma_done);
		chk("stop flag", 1, conversion_done_flag);
		dma_mode = 0;
		flag_sw_clear = 1;
		tick;
		flag_sw_clear = 0;
		$display("dma test done");
		// Every average code, both calibration kinds
		for (int a = 0; a < 4; a++) begin
			w = {2'b00, a[1:0], 2'b01, a[0], 1'b1};
			wr(w);
			chk("cal route", a[0] ? 16'h0001 : 16'h0002, route);
			rdr(CAL_CTRL_ADDR);
			chk("cal busy", w | 8'h80, rd);
			conv_req = (a == 1);
			n = 0;
			repeat (2000) if (!cal_update) begin tick; conv_req = 0; n += conv_start; end
			chk("readings", (a == 0) ? 15 : (a == 1) ? 1 : (a == 2) ? 31 : 63, n);
			chk("cal update", 1, cal_update);
			chk("cal kind", a[0], cal_is_gain);
			rdr(CAL_CTRL_ADDR);
			chk("cal end", w & 8'h7e, rd);
		end
		// Gain calibration disabled takes no readings
		wr(8'h47);
		n = 0;
		repeat (10) begin tick; n += conv_start + cal_update; end
		chk("gain skip", 0, n);
		rdr(CAL_CTRL_ADDR);
		chk("skip end", 8'h46, rd);
		$display("calibration test done");
		report_and_stop;
	end
endmodule
bind adc_cal_ctrl adc_cal_sva #(.ACQ_CYCLES(ACQ_CYCLES)) sva_u (.core_clk(core_clk),
	.nrst(nrst), .sfr(sfr), .dma_id_valid(dma_id_valid), .dma_chan_id(dma_chan_id),
	.int_vector_ack(int_vector_ack), .flag_sw_clear(flag_sw_clear), .sar_done(sar_done),
	.sfr_rdata(sfr_rdata), .dma_id_ready(dma_id_ready), .dma_done(dma_done),
	.conversion_done_flag(conversion_done_flag), .conv_start(conv_start),
	.sample_track(sample_track), .route(route), .result_valid(result_valid),
	.cal_update(cal_update));
`default_nettype wire
